// ### bench/serial_host_model.sv
// Host model for the two-wire serial bus: open-drain data, clock held high
// between frames. Assumes the bench resolves the data wire into sda_line.
`timescale 1ns/100ps
module serial_host_model (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    logic ack;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    // ==========================================================
    // Bit level
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Data moves only while the clock is low, one cycle clear of its fall
    task automatic bit_io(input logic b, output logic s);
        sda_drv <= b;
        hold(4);
        scl <= 1'b1;
        hold(4);
        s = sda_line;
        scl <= 1'b0;
        hold(1);
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda_drv <= 1'b0;
        hold(4);
        scl <= 1'b0;
        hold(4);
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda_drv <= 1'b1;
        hold(4);
    endtask
    // ==========================================================
    // Byte level
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit_io(v[i], ack);
        bit_io(1'b1, ack);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
        start();
        send({a, 1'b0});
        send(r);
        send(d);
        stop();
    endtask
    // Single byte read, ended by a refusal so the pointer does not move
    task automatic rd(input logic [6:0] a, input logic [7:0] r);
        logic [7:0] v;
        start();
        send({a, 1'b0});
        send(r);
        start();
        send({a, 1'b1});
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(1'b1, ack);
        stop();
        rd_data <= v;
        rd_valid <= 1'b1;
        hold(1);
        rd_valid <= 1'b0;
    endtask
endmodule

// ### bench/test_backlight_enable_brightness_ctrl.sv
// Bench for the backlight control block: host model on the bus, PWM level
// driven here. Assumes shortened idle and turn-on parameters.
`timescale 1ns/100ps
module test_backlight_enable_brightness_ctrl;
    import backlight_pkg::*;
    logic mclk, reset_n, master_enable_pin, bus_address_select_pin, pwm_in;
    logic scl, sda_drv, snap, rd_valid, sda_out, sda_oe;
    logic exp_mapping, device_enabled, device_standby, backlight_on;
    logic [10:0] led_code, code_c, prod_c;
    logic [2:0] string_enable;
    logic [7:0] rd_data;
    logic [6:0] addr;
    logic [31:0] seed = 32'h0000DDE3;
    logic [17:0] st_q[$];
    logic [7:0] rd_q[$];
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    wire logic sda_line = sda_drv & ~sda_oe;

    backlight_enable_brightness_ctrl #(.IDLE_FAST(15'h0028), .IDLE_MID(15'h0028), .IDLE_SLOW(15'h0028),
        .TURN_ON(19'h00014), .BUS_ADDR_HI(6'h1B)) u_dut (.mclk(mclk), .reset_n(reset_n),
        .master_enable_pin(master_enable_pin), .bus_address_select_pin(bus_address_select_pin),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pwm_in(pwm_in),
        .led_code(led_code), .string_enable(string_enable), .exp_mapping(exp_mapping),
        .device_enabled(device_enabled), .device_standby(device_standby), .backlight_on(backlight_on));
    serial_host_model u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv),
        .rd_data(rd_data), .rd_valid(rd_valid));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic note_st(input logic [17:0] e);
        wait_n(60);
        st_q.push_back(e);
        snap <= 1'b1;
        wait_n(1);
        snap <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] r, input logic [7:0] e);
        rd_q.push_back(e);
        u_host.rd(addr, r);
    endtask
    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Watcher: sampled on the falling edge, clear of register updates
    always @(negedge mclk) begin
        if (snap === 1'b1)
            check({led_code, string_enable, exp_mapping, device_enabled, device_standby, backlight_on},
                st_q.pop_front());
        if (rd_valid === 1'b1)
            check({10'h000, rd_data}, {10'h000, rd_q.pop_front()});
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        master_enable_pin = 1'b1;
        pwm_in = 1'b0;
        snap = 1'b0;
        seed = xs(seed);
        bus_address_select_pin = seed[0];
        addr = {6'h1B, seed[0]};
        seed = xs(seed);
        code_c = {seed[7:0] | 8'h01, seed[10:8]};
        prod_c = 11'((22'(code_c) * 22'h0007FF) >> 11);
        wait_n(16);
        reset_n <= 1'b1;
        note_st({11'h000, 3'h0, 4'b0110});
        pwm_in <= 1'b1;
        wait_n(6000);
        note_st({CODE_MAX, 3'h7, 4'b0101});
        rd_chk(ENABLE_ADDR, 8'h0F);
        rd_chk(CONTROL_ADDR, CONTROL_RST);
        rd_chk(8'h33, 8'h00);
        u_host.wr(addr, CODE_LO_ADDR, {5'h00, code_c[2:0]});
        u_host.wr(addr, CODE_HI_ADDR, code_c[10:3]);
        for (int m = 0; m < 4; m++) begin
            u_host.wr(addr, CONTROL_ADDR, {m[0], m[1:0], 5'h00});
            note_st({m == 0 ? code_c : m == 1 ? CODE_MAX : prod_c, 3'h7, m[0], 3'b101});
        end
        u_host.wr(addr, ENABLE_ADDR, 8'h05);
        note_st({prod_c, 3'h2, 4'b1101});
        u_host.wr(addr, ENABLE_ADDR, 8'h01);
        note_st({11'h000, 3'h0, 4'b1110});
        u_host.wr(addr, ENABLE_ADDR, 8'h0E);
        note_st({11'h000, 3'h0, 4'b1000});
        rd_chk(CODE_HI_ADDR, code_c[10:3]);
        u_host.wr(addr, ENABLE_ADDR, 8'h0F);
        u_host.wr(addr, CONTROL_ADDR, 8'h00);
        u_host.wr(addr, CODE_HI_ADDR, 8'h00);
        u_host.wr(addr, CODE_LO_ADDR, 8'h00);
        note_st({11'h000, 3'h0, 4'b0110});
        master_enable_pin <= 1'b0;
        note_st(18'h00000);
        rd_chk(CONTROL_ADDR, 8'hFF);
        master_enable_pin <= 1'b1;
        wait_n(40);
        rd_chk(CONTROL_ADDR, CONTROL_RST);
        u_host.wr(addr, CODE_LO_ADDR, 8'h03);
        rd_chk(CODE_LO_ADDR, 8'h03);
        // Fast sampling, widest filter: a 15-cycle low pulse must not break the idle-high code
        u_host.wr(addr, SAMPLE_ADDR, 8'hC3);
        wait_n(200);
        pwm_in <= 1'b0;
        wait_n(15);
        pwm_in <= 1'b1;
        note_st({CODE_MAX, 3'h7, 4'b0101});
        wait_n(4);
        results();
    end
endmodule

// ### design/backlight_enable_brightness_ctrl.sv
// Backlight enable and brightness-source control: register file behind a
// two-wire serial slave, operating state and selection of the LED code.
// Assumes scl, sda, pwm and enable pins are synchronous to mclk and that
// the analog sink applies the mapping to led_code.
`timescale 1ns/100ps
// Functional notes
// R1 - Enable pin low: defaults, bus ignored, shutdown
// R2 - Enable pin high: device on, writes accepted
// R3 - Per-string enable bits, all on at reset
// R4 - No strings enabled: LEDs off, standby
// R5 - Chip enable zero: LEDs off, disabled
// R6 - Reset: chip enabled, PWM source selected
// R7 - Mapping select bit, linear by default
// R8 - Linear or exponential current mapping
// R9 - Standby watches PWM, converts duty to code
// R10 - Standby keeps all programmed registers
// R11 - Register code from two registers
// R12 - Source select: register, PWM or product
// R13 - Zero source value: LEDs off, standby
// R14 - Selectable PWM glitch rejection width
// R15 - PWM inactivity timeout per sample rate
// R16 - Backlight on within turn-on delay
// R17 - Code zero gives zero current
// R18 - Duty measured by counting high samples
module backlight_enable_brightness_ctrl #(
    parameter logic [14:0] IDLE_FAST = 15'(backlight_pkg::IDLE_FAST_SMP),
    parameter logic [14:0] IDLE_MID = 15'(backlight_pkg::IDLE_MID_SMP),
    parameter logic [14:0] IDLE_SLOW = 15'(backlight_pkg::IDLE_SLOW_SMP),
    parameter logic [18:0] TURN_ON = 19'(backlight_pkg::TURN_ON_CYC),
    // Upper six bits of the bus address; value is arbitrary
    parameter logic [5:0] BUS_ADDR_HI = 6'h1B
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic master_enable_pin,
    input wire logic bus_address_select_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic pwm_in,
    output logic [10:0] led_code,
    output logic [2:0] string_enable,
    output logic exp_mapping,
    output logic device_enabled,
    output logic device_standby,
    output logic backlight_on
);
    import backlight_pkg::*;

    logic [3:0] en_r;
    logic [7:0] ctl_r, smp_r, code_hi_r;
    logic [2:0] code_lo_r;

    bus_state_e bst_r;
    logic scl_q, sda_q, scl_rise, scl_fall, bus_start, bus_stop;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, rsh_r, ptr_r, rd_byte, rd_next;
    logic rw_r;
    logic wr_stb_r;
    logic [7:0] wr_addr_r, wr_data_r;

    logic [6:0] div_r;
    logic smp_en_r;
    logic pwm_clean, pwm_idle;
    logic [10:0] pwm_code, reg_code, src_code;
    logic [14:0] idle_lim;
    logic [21:0] prod;

    dev_state_e st_r, st_nxt;
    logic [18:0] start_cnt_r;

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        case (a)
            ENABLE_ADDR: read_reg = {4'h0, en_r};
            CONTROL_ADDR: read_reg = ctl_r;
            SAMPLE_ADDR: read_reg = smp_r;
            CODE_LO_ADDR: read_reg = {5'h00, code_lo_r};
            CODE_HI_ADDR: read_reg = code_hi_r;
            default: read_reg = 8'h00;
        endcase
    endfunction

    assign rd_byte = read_reg(ptr_r);
    assign rd_next = read_reg(ptr_r + 8'h01);

    // ==========================================================
    // Serial bus line tracking
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign bus_start = scl_in && scl_q && sda_q && !sda_in;
    assign bus_stop = scl_in && scl_q && !sda_q && sda_in;

    // ==========================================================
    // Serial slave: address, register pointer, then data bytes.
    // The pointer advances after each written byte and each acknowledged read byte so bursts walk the map.
    always_ff @(posedge mclk) begin
        if (!reset_n || !master_enable_pin) begin // [R1]
            bst_r <= BUS_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rsh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (bus_start) begin
                bst_r <= BUS_ADDR;
                cnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                bst_r <= BUS_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (bst_r == BUS_RACK && sda_in) begin
                    bst_r <= BUS_IDLE;
                end else if (bst_r inside {BUS_ADDR, BUS_REG, BUS_WDATA, BUS_RDATA}) begin
                    sh_r <= {sh_r[6:0], sda_in};
                    cnt_r <= cnt_r + 4'h1;
                end
            end else if (scl_fall) begin
                case (bst_r)
                    BUS_ADDR: begin
                        if (cnt_r == BYTE_BITS) begin
                            if (sh_r[7:1] == {BUS_ADDR_HI, bus_address_select_pin}) begin
                                bst_r <= BUS_AACK;
                                rw_r <= sh_r[0];
                                sda_oe <= 1'b1;
                            end else begin
                                bst_r <= BUS_IDLE;
                            end
                        end
                    end
                    BUS_AACK: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            bst_r <= BUS_RDATA;
                            rsh_r <= rd_byte;
                            sda_oe <= !rd_byte[7];
                        end else begin
                            bst_r <= BUS_REG;
                            sda_oe <= 1'b0;
                        end
                    end
                    BUS_REG: begin
                        if (cnt_r == BYTE_BITS) begin
                            ptr_r <= sh_r;
                            bst_r <= BUS_PACK;
                            sda_oe <= 1'b1;
                        end
                    end
                    BUS_PACK, BUS_WACK: begin
                        bst_r <= BUS_WDATA;
                        cnt_r <= 4'h0;
                        sda_oe <= 1'b0;
                    end
                    BUS_WDATA: begin
                        if (cnt_r == BYTE_BITS) begin // [R2]
                            wr_stb_r <= 1'b1;
                            wr_addr_r <= ptr_r;
                            wr_data_r <= sh_r;
                            ptr_r <= ptr_r + 8'h01;
                            bst_r <= BUS_WACK;
                            sda_oe <= 1'b1;
                        end
                    end
                    BUS_RDATA: begin
                        if (cnt_r == BYTE_BITS) begin
                            sda_oe <= 1'b0;
                            bst_r <= BUS_RACK;
                        end else begin
                            rsh_r <= {rsh_r[6:0], 1'b0};
                            sda_oe <= !rsh_r[6];
                        end
                    end
                    BUS_RACK: begin
                        ptr_r <= ptr_r + 8'h01;
                        rsh_r <= rd_next;
                        sda_oe <= !rd_next[7];
                        cnt_r <= 4'h0;
                        bst_r <= BUS_RDATA;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Register file; contents survive standby, only reset or the pin clears them
    always_ff @(posedge mclk) begin
        if (!reset_n || !master_enable_pin) begin // [R1]
            en_r <= ENABLE_RST; // [R3] [R6]
            ctl_r <= CONTROL_RST; // [R6] [R7]
            smp_r <= SAMPLE_RST;
            code_lo_r <= CODE_RST[2:0];
            code_hi_r <= CODE_RST;
        end else if (wr_stb_r) begin // [R2] [R10]
            case (wr_addr_r)
                ENABLE_ADDR: en_r <= wr_data_r[3:0];
                CONTROL_ADDR: ctl_r <= wr_data_r;
                SAMPLE_ADDR: smp_r <= wr_data_r;
                CODE_LO_ADDR: code_lo_r <= wr_data_r[2:0];
                CODE_HI_ADDR: code_hi_r <= wr_data_r;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // PWM sampling path
    always_comb begin
        case (smp_r[RATE_LSB+:2])
            2'h0: idle_lim = IDLE_SLOW;
            2'h1: idle_lim = IDLE_MID;
            default: idle_lim = IDLE_FAST;
        endcase
    end

    // Sample tick stops in shutdown to save power
    always_ff @(posedge mclk) begin
        if (!reset_n || st_r == DEV_OFF) begin
            div_r <= 7'h00;
            smp_en_r <= 1'b0;
        end else if (div_r >= (smp_r[RATE_LSB+:2] == 2'h0 ? DIV_SLOW :
                               smp_r[RATE_LSB+:2] == 2'h1 ? DIV_MID : DIV_FAST) - 7'h01) begin
            div_r <= 7'h00;
            smp_en_r <= 1'b1;
        end else begin
            div_r <= div_r + 7'h01;
            smp_en_r <= 1'b0;
        end
    end

    pwm_glitch_filter u_filter (
        .mclk(mclk),
        .reset_n(reset_n),
        .pwm_in(pwm_in),
        .filt_sel(smp_r[FILT_LSB+:2]), // [R14]
        .pwm_clean(pwm_clean)
    );

    pwm_duty_meter u_meter (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(st_r == DEV_OFF),
        .sample_en(smp_en_r), // [R9]
        .pwm_level(pwm_clean),
        .idle_limit(idle_lim), // [R15]
        .duty_code(pwm_code),
        .pwm_idle(pwm_idle)
    );

    // ==========================================================
    // Brightness source
    assign reg_code = {code_hi_r, code_lo_r}; // [R11]
    assign prod = reg_code * pwm_code;

    always_comb begin
        case (ctl_r[MODE_LSB+:2]) // [R12]
            SRC_REG: src_code = reg_code;
            SRC_PWM: src_code = pwm_code;
            default: begin
                // A non-zero product never truncates to zero
                if (reg_code == 11'h000 || pwm_code == 11'h000) begin // [R13]
                    src_code = 11'h000;
                end else if (prod[21:11] == 11'h000) begin
                    src_code = 11'h001;
                end else begin
                    src_code = prod[21:11];
                end
            end
        endcase
    end

    // ==========================================================
    // Operating state
    always_ff @(posedge mclk) begin
        if (!reset_n || !master_enable_pin) begin
            start_cnt_r <= 19'h00000;
        end else if (start_cnt_r != TURN_ON) begin // [R16]
            start_cnt_r <= start_cnt_r + 19'h00001;
        end
    end

    always_comb begin
        if (!master_enable_pin || !en_r[CHIP_EN_BIT]) begin // [R1] [R5]
            st_nxt = DEV_OFF;
        end else if (start_cnt_r != TURN_ON) begin // [R16]
            st_nxt = DEV_STARTUP;
        end else if (en_r[STR_LSB+:3] == 3'h0 || src_code == 11'h000) begin // [R4] [R13]
            st_nxt = DEV_STANDBY;
        end else begin
            st_nxt = DEV_ACTIVE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r <= DEV_OFF;
            led_code <= 11'h000;
            string_enable <= 3'h0;
            exp_mapping <= 1'b0;
            device_enabled <= 1'b0;
            device_standby <= 1'b0;
            backlight_on <= 1'b0;
        end else begin
            st_r <= st_nxt;
            led_code <= st_nxt == DEV_ACTIVE ? src_code : 11'h000; // [R8] [R17]
            string_enable <= st_nxt == DEV_ACTIVE ? en_r[STR_LSB+:3] : 3'h0; // [R3]
            exp_mapping <= ctl_r[MAP_BIT]; // [R7] [R8]
            device_enabled <= st_nxt != DEV_OFF;
            device_standby <= st_nxt == DEV_STANDBY || st_nxt == DEV_STARTUP; // [R9]
            backlight_on <= st_nxt == DEV_ACTIVE;
        end
    end

    // ==========================================================
    // Checks
    regs_default_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
        !master_enable_pin |=> en_r == ENABLE_RST && ctl_r == CONTROL_RST && code_hi_r == CODE_RST)
        else $error("Registers not at defaults while disabled");
    bus_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
        !master_enable_pin |=> !sda_oe && bst_r == BUS_IDLE)
        else $error("Serial bus active while disabled");
    chip_off_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
        !en_r[CHIP_EN_BIT] |=> !backlight_on && !device_enabled)
        else $error("LEDs on with chip enable low");
    no_string_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
        master_enable_pin && en_r[STR_LSB+:3] == 3'h0 |=> !backlight_on && string_enable == 3'h0)
        else $error("LEDs on with no string enabled");
    on_code_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R17]
        backlight_on |-> led_code != 11'h000 && string_enable != 3'h0 && device_enabled)
        else $error("Backlight on with zero code or no string");
    reg_zero_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
        ctl_r[MODE_LSB+:2] != SRC_PWM && reg_code == 11'h000 |=> led_code == 11'h000)
        else $error("Zero register code drove LEDs");
    turn_on_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R16]
        $rose(master_enable_pin) |=> (!backlight_on)[*8])
        else $error("Backlight on before turn-on delay");
    write_take_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R11]
        wr_stb_r && master_enable_pin && wr_addr_r == CODE_HI_ADDR |=> code_hi_r == $past(wr_data_r))
        else $error("Brightness code write lost");

endmodule

// ### design/pwm_duty_meter.sv
// PWM duty meter: counts high samples over each rising-to-rising period
// and divides them into an 11-bit code; also flags an idle input.
// Assumes sample_en is a one-cycle pulse at the chosen sample rate.
`timescale 1ns/100ps
module pwm_duty_meter (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic sample_en,
    input wire logic pwm_level,
    input wire logic [14:0] idle_limit,
    output logic [10:0] duty_code,
    output logic pwm_idle
);
    import backlight_pkg::*;

    logic lvl_q;
    logic [15:0] hi_cnt_r, per_cnt_r, den_r;
    logic [14:0] idle_r;
    logic [16:0] rem_r;
    logic [11:0] quo_r;
    logic [3:0] step_r;
    logic [10:0] duty_r;
    logic start, ge;

    assign start = sample_en && pwm_level && !lvl_q && per_cnt_r != 16'h0000;
    assign ge = rem_r >= {1'b0, den_r};

    // ==========================================================
    // Sample counters
    always_ff @(posedge mclk) begin
        if (!reset_n || clear) begin
            lvl_q <= 1'b0;
            hi_cnt_r <= 16'h0000;
            per_cnt_r <= 16'h0000;
            idle_r <= 15'h0000;
        end else if (sample_en) begin
            lvl_q <= pwm_level;
            if (pwm_level && !lvl_q) begin // [R18]
                hi_cnt_r <= 16'h0001;
                per_cnt_r <= 16'h0001;
            end else if (!(&per_cnt_r)) begin
                per_cnt_r <= per_cnt_r + 16'h0001;
                hi_cnt_r <= hi_cnt_r + {15'h0000, pwm_level};
            end
            if (pwm_level != lvl_q) begin
                idle_r <= 15'h0000;
            end else if (idle_r != idle_limit) begin // [R15]
                idle_r <= idle_r + 15'h0001;
            end
        end
    end

    // ==========================================================
    // Serial divider: code = high * 2048 / period, saturated
    // Twelve cycles per period; far shorter than any legal PWM period.
    always_ff @(posedge mclk) begin
        if (!reset_n || clear) begin
            den_r <= 16'h0000;
            rem_r <= 17'h00000;
            quo_r <= 12'h000;
            step_r <= 4'h0;
            duty_r <= 11'h000;
        end else if (start) begin
            den_r <= per_cnt_r;
            rem_r <= {1'b0, hi_cnt_r};
            quo_r <= 12'h000;
            step_r <= 4'hC;
        end else if (step_r != 4'h0) begin
            quo_r <= {quo_r[10:0], ge};
            rem_r <= 17'((ge ? rem_r - {1'b0, den_r} : rem_r) << 1);
            step_r <= step_r - 4'h1;
            if (step_r == 4'h1) begin // [R18]
                duty_r <= quo_r[10] ? CODE_MAX : {quo_r[9:0], ge};
            end
        end
    end

    assign pwm_idle = idle_r == idle_limit;
    // A stuck-high input counts as full duty, stuck-low as zero
    assign duty_code = pwm_idle ? (lvl_q ? CODE_MAX : 11'h000) : duty_r; // [R15]

endmodule

// ### design/pwm_glitch_filter.sv
// PWM pulse filter: a level change is taken only after it has held
// for longer than the selected reject width.
// Assumes pwm_in is already synchronous to mclk.
`timescale 1ns/100ps
module pwm_glitch_filter (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pwm_in,
    input wire logic [1:0] filt_sel,
    output logic pwm_clean
);
    import backlight_pkg::*;

    logic [4:0] cnt_r;

    function automatic logic [4:0] reject_cyc(input logic [1:0] s);
        case (s)
            2'h1: reject_cyc = GLITCH1_CYC;
            2'h2: reject_cyc = GLITCH2_CYC;
            2'h3: reject_cyc = GLITCH3_CYC;
            default: reject_cyc = 5'h00;
        endcase
    endfunction

    // A mismatch lasting reject_cyc cycles or less is dropped
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_r <= 5'h00;
            pwm_clean <= 1'b0;
        end else if (pwm_in == pwm_clean) begin
            cnt_r <= 5'h00;
        end else if (cnt_r >= reject_cyc(filt_sel)) begin // [R14]
            pwm_clean <= pwm_in;
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

endmodule

// ### shared/backlight_pkg.sv
// Constants, register map and state types for the backlight control block.
// Assumes a 100 MHz mclk; every time below is turned into cycles here, except the idle times, which become samples.
package backlight_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ENABLE_ADDR = 8'h10;
    localparam logic [7:0] CONTROL_ADDR = 8'h11;
    localparam logic [7:0] SAMPLE_ADDR = 8'h12;
    localparam logic [7:0] CODE_LO_ADDR = 8'h18;
    localparam logic [7:0] CODE_HI_ADDR = 8'h19;

    localparam logic [3:0] ENABLE_RST = 4'hF;
    localparam logic [7:0] CONTROL_RST = 8'h20;
    localparam logic [7:0] SAMPLE_RST = 8'h00;
    localparam logic [7:0] CODE_RST = 8'h00;

    localparam int CHIP_EN_BIT = 0;
    localparam int STR_LSB = 1;
    localparam int MAP_BIT = 7;
    localparam int MODE_LSB = 5;
    localparam int RATE_LSB = 6;
    localparam int FILT_LSB = 0;

    localparam logic [1:0] SRC_REG = 2'h0;
    localparam logic [1:0] SRC_PWM = 2'h1;
    localparam logic [10:0] CODE_MAX = 11'h7FF;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int GLITCH1_NS = 100;
    localparam int GLITCH2_NS = 150;
    localparam int GLITCH3_NS = 200;
    localparam logic [4:0] GLITCH1_CYC = 5'(GLITCH1_NS * CLK_MHZ / 1000);
    localparam logic [4:0] GLITCH2_CYC = 5'(GLITCH2_NS * CLK_MHZ / 1000);
    localparam logic [4:0] GLITCH3_CYC = 5'(GLITCH3_NS * CLK_MHZ / 1000);

    localparam int RATE_FAST_KHZ = 24000;
    localparam int RATE_MID_KHZ = 4000;
    localparam int RATE_SLOW_KHZ = 800;
    localparam logic [6:0] DIV_FAST = 7'(CLK_MHZ * 1000 / RATE_FAST_KHZ);
    localparam logic [6:0] DIV_MID = 7'(CLK_MHZ * 1000 / RATE_MID_KHZ);
    localparam logic [6:0] DIV_SLOW = 7'(CLK_MHZ * 1000 / RATE_SLOW_KHZ);

    localparam int IDLE_FAST_US = 600;
    localparam int IDLE_MID_US = 3000;
    localparam int IDLE_SLOW_US = 25000;
    localparam int IDLE_FAST_SMP = IDLE_FAST_US * RATE_FAST_KHZ / 1000;
    localparam int IDLE_MID_SMP = IDLE_MID_US * RATE_MID_KHZ / 1000;
    localparam int IDLE_SLOW_SMP = IDLE_SLOW_US * RATE_SLOW_KHZ / 1000;

    localparam int TURN_ON_US = 3500;
    localparam int TURN_ON_CYC = TURN_ON_US * CLK_MHZ;

    // ==========================================================
    // States
    typedef enum logic [3:0] {
        BUS_IDLE, BUS_ADDR, BUS_AACK, BUS_REG, BUS_PACK,
        BUS_WDATA, BUS_WACK, BUS_RDATA, BUS_RACK
    } bus_state_e;

    typedef enum logic [1:0] {
        DEV_OFF, DEV_STARTUP, DEV_STANDBY, DEV_ACTIVE
    } dev_state_e;

endpackage
